/* File: tb/ufi_host.sv */
`timescale 1ns/1ps
module ufi_host (
  // clock and answer
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // request
  output logic hsel = 1'b0,
  output logic [31:0] haddr = 32'h0000_0000,
  output logic [1:0] htrans = 2'b00,
  output logic hwrite = 1'b0,
  output logic [2:0] hsize = 3'h2,
  output logic [31:0] hwdata = 32'h0000_0000
);
  // one word transfer; each phase holds until hready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule

/* File: tb/ufi_uart_irq_properties.sv */
`timescale 1ns/1ps
module ufi_uart_irq_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // status
  input wire logic irq_output,
  input wire ufi_pkg::ufi_fmt_type line_fmt,
  input wire logic fifo_on
);
  import ufi_pkg::*;
  // ****************
  // shadow registers
  // ****************
  logic ph_q;
  logic wr_q;
  logic fs_q;
  logic [7:0] ad_q;
  logic [3:0] ien_q;
  logic [2:0] lfc_q;
  wire taken = hsel && htrans[1] && hready;
  wire wr_now = ph_q && wr_q;
  // setup writes are mirrored here; of the fifo setup write only the enable bit is kept
  wire fs_d = (wr_now && ad_q == OFS_IID_FS) ? hwdata[0] : fs_q;
  wire [3:0] ien_d = (wr_now && ad_q == OFS_IEN) ? hwdata[3:0] : ien_q;
  wire [2:0] lfc_d = (wr_now && ad_q == OFS_LFC) ? hwdata[2:0] : lfc_q;
  // data phase marker and shadows
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ph_q <= 1'b0;
      fs_q <= 1'b0;
      ien_q <= 4'h0;
      lfc_q <= 3'h0;
    end else begin
      ph_q <= taken;
      fs_q <= fs_d;
      ien_q <= ien_d;
      lfc_q <= lfc_d;
    end
  end
  // request latch, only looked at while ph_q is high
  always_ff @(posedge clk) begin
    if (taken) begin
      ad_q <= haddr[7:0];
      wr_q <= hwrite;
    end
  end
  // ***********
  // properties
  // ***********
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd(logic [7:0] a);
    ph_q && !wr_q && ad_q == a;
  endsequence
  a_bus_okay:
    assert property (hresp == 1'b0) else $error("response not okay");
  a_one_wait:
    assert property (taken |=> !hreadyout ##1 hreadyout) else $error("wait state count wrong");
  a_data_bits:
    assert property ($stable(lfc_q) |-> line_fmt.data_bits == 4'h5 + {2'b00, lfc_q[1:0]})
    else $error("word length wrong");
  a_stop_bits:
    assert property ($stable(lfc_q) |->
      line_fmt.stop_halves == (!lfc_q[2] ? 3'h2 : (lfc_q[1:0] == 2'b00) ? 3'h3 : 3'h4))
    else $error("stop count wrong");
  a_fifo_follow:
    assert property ($stable(fs_q) |-> fifo_on == fs_q) else $error("fifo enable wrong");
  a_irq_masked:
    assert property (ien_q == 4'h0 |-> !irq_output) else $error("interrupt while all masked");
  a_ien_read:
    assert property (s_rd(OFS_IEN) |=> hrdata[7:0] == {4'h0, ien_q}) else $error("enables read wrong");
  a_iid_high:
    assert property (s_rd(OFS_IID_FS) |=> hrdata[7:4] == {fifo_on, fifo_on, 2'b00}) else $error("id high bits wrong");
  a_iid_pending:
    assert property (s_rd(OFS_IID_FS) |=> hrdata[0] == !$past(irq_output)) else $error("pending bit wrong");
  a_tmo_code:
    assert property (s_rd(OFS_IID_FS) |=> !hrdata[3] || (hrdata[2] && fifo_on)) else $error("timeout code wrong");
endmodule

bind ufi_uart_irq ufi_uart_irq_checker chk_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .irq_output(irq_output), .line_fmt(line_fmt), .fifo_on(fifo_on));

/* File: tb/ufi_uart_irq_test.sv */
`timescale 1ns/1ps
module ufi_uart_irq_test;
  import ufi_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rclk = 1'b0;
  logic rx_push = 1'b0;
  ufi_rx_char_type rx_char = '0;
  logic tx_pop = 1'b0;
  logic tx_busy = 1'b0;
  ufi_modem_type modem_in = '0;
  int n_errors = 0;
  int checks = 0;
  wire hsel, hwrite, hreadyout, tx_avail, irq_output;
  wire [1:0] htrans;
  wire [2:0] hsize;
  wire [31:0] haddr, hwdata, hrdata;
  wire [7:0] tx_data;
  ufi_fmt_type line_fmt;
  // clocks: rclk runs at a quarter of clk, well inside the sync limit
  always #50 clk = ~clk;
  always #200 rclk = ~rclk;
  ufi_host host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  ufi_uart_irq dut (.clk(clk), .rst(rst), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .rx_push(rx_push), .rx_char(rx_char), .tx_pop(tx_pop),
    .tx_shift_busy(tx_busy), .tx_avail(tx_avail), .tx_data(tx_data), .rclk(rclk), .modem_in(modem_in),
    .irq_output(irq_output), .line_fmt(line_fmt), .fifo_on());
  // ***********
  // helpers
  // ***********
  task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, {24'h00_0000, d}, q);
  endtask
  task automatic rx(string n, logic [7:0] a, logic [31:0] e);
    logic [31:0] q;
    host.xfer(1'b0, a, 32'h0000_0000, q);
    chk(n, q, e);
  endtask
  task automatic push(logic [10:0] c);
    rx_push <= 1'b1;
    rx_char <= c;
    @(posedge clk);
    rx_push <= 1'b0;
    @(posedge clk);
  endtask
  // waits for the interrupt line, bounded
  task automatic wait_irq(int n);
    repeat (n) begin
      if (irq_output === 1'b1) break;
      @(posedge clk);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ***********
  // scenarios
  // ***********
  task automatic t_regs();
    rx("iid", OFS_IID_FS, 32'h0000_0001); // none pending
    rx("lsf", OFS_LSF, 32'h0000_0060); // tx empty
    wr(OFS_IEN, 8'hF0);
    rx("ien", OFS_IEN, 32'h0000_0000); // upper zero
    rx("unmapped", 8'h3C, 32'h0000_0000);
    $display("regs done");
  endtask
  task automatic t_fmt();
    for (int i = 0; i < 8; i++) begin
      wr(OFS_LFC, 8'(i));
      @(posedge clk);
      chk("bits", 32'(line_fmt.data_bits), 32'(5 + i % 4)); // word length
      chk("stop", 32'(line_fmt.stop_halves), (i < 4) ? 2 : (i == 4) ? 3 : 4); // stop count
    end
    wr(OFS_LFC, 8'h00);
    $display("fmt done");
  endtask
  // error char first so it sits at the head of the fifo
  task automatic t_rx();
    wr(OFS_IID_FS, 8'h41);
    wr(OFS_IEN, 8'h05);
    rx("iid_on", OFS_IID_FS, 32'h0000_00C1); // fifo bits
    push(11'h155);
    repeat (2) push(11'h0AA);
    rx("line", OFS_IID_FS, 32'h0000_00C6); // parity error
    rx("lsf_err", OFS_LSF, 32'h0000_00E5); // error flags
    chk("below", 32'(irq_output), 32'h0000_0000); // below trigger
    push(11'h0AA);
    chk("at_lvl", 32'(irq_output), 32'h0000_0001); // output raised
    rx("rxdata", OFS_IID_FS, 32'h0000_00C4); // trigger code
    rx("data", OFS_RX_TX, 32'h0000_0055); // read clears
    chk("dropped", 32'(irq_output), 32'h0000_0000); // under trigger
    rx("ready", OFS_LSF, 32'h0000_0061); // data ready
    $display("rx done");
  endtask
  task automatic t_tmo();
    wait_irq(3000);
    rx("tmo", OFS_IID_FS, 32'h0000_00CC); // timeout code
    rx("tmo_rd", OFS_RX_TX, 32'h0000_00AA); // read clears
    repeat (1000) @(posedge clk);
    chk("restart", 32'(irq_output), 32'h0000_0000); // timer restarted
    repeat (2) rx("drain", OFS_RX_TX, 32'h0000_00AA);
    rx("empty", OFS_LSF, 32'h0000_0060); // cleared when empty
    $display("timeout done");
  endtask
  task automatic t_tx();
    wr(OFS_IID_FS, 8'h00);
    wr(OFS_IID_FS, 8'h01);
    wr(OFS_IEN, 8'h02);
    rx("tx_holding_empty", OFS_IID_FS, 32'h0000_00C2); // immediate after toggle
    chk("id_clr", 32'(irq_output), 32'h0000_0000); // id read clears
    wr(OFS_IEN, 8'h00);
    wr(OFS_IEN, 8'h02);
    wr(OFS_RX_TX, 8'h33);
    chk("wr_clr", 32'(irq_output), 32'h0000_0000); // write clears
    chk("tx_avail", 32'(tx_avail), 32'h0000_0001);
    chk("tx_data", 32'(tx_data), 32'h0000_0033);
    tx_pop <= 1'b1;
    @(posedge clk);
    tx_pop <= 1'b0;
    tx_busy <= 1'b1;
    rx("busy_lsf", OFS_LSF, 32'h0000_0020); // shift register busy
    tx_busy <= 1'b0;
    repeat (300) @(posedge clk);
    chk("tx_dly", 32'(irq_output), 32'h0000_0000); // empty indication delayed
    repeat (200) @(posedge clk);
    chk("tx_late", 32'(irq_output), 32'h0000_0001); // interrupt once empty
    $display("tx done");
  endtask
  task automatic t_poll();
    wr(OFS_IEN, 8'h00);
    push(11'h011);
    repeat (2000) @(posedge clk);
    rx("poll_iid", OFS_IID_FS, 32'h0000_00C1); // nothing reported
    rx("poll_lsf", OFS_LSF, 32'h0000_0061); // still stored
    $display("poll done");
  endtask
  task automatic t_mdm();
    wr(OFS_IEN, 8'h08);
    modem_in.cts <= 1'b1;
    repeat (4) @(posedge clk);
    rx("mdm_iid", OFS_IID_FS, 32'h0000_00C0); // lowest source
    rx("mdm_rd", OFS_MIF, 32'h0000_0011); // cts change seen
    chk("mdm_clr", 32'(irq_output), 32'h0000_0000); // read clears
    $display("modem done");
  endtask
  // ***********
  // main run
  // ***********
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_fmt();
    t_rx();
    t_tmo();
    t_tx();
    t_poll();
    t_mdm();
    report_and_stop();
  end
  // hang guard, several times the expected run
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
endmodule

/* File: verilog/ufi_pkg.sv */
package ufi_pkg;

  // ****************************************************************
  // register map: printed indices, byte address is four times index
  // ****************************************************************
  localparam int IDX_RX_TX = 0;
  localparam int IDX_IEN = 1;
  localparam int IDX_IID_FS = 2;
  localparam int IDX_LFC = 3;
  localparam int IDX_LSF = 5;
  localparam int IDX_MIF = 6;
  localparam logic [7:0] OFS_RX_TX = 8'(IDX_RX_TX * 4);
  localparam logic [7:0] OFS_IEN = 8'(IDX_IEN * 4);
  localparam logic [7:0] OFS_IID_FS = 8'(IDX_IID_FS * 4);
  localparam logic [7:0] OFS_LFC = 8'(IDX_LFC * 4);
  localparam logic [7:0] OFS_LSF = 8'(IDX_LSF * 4);
  localparam logic [7:0] OFS_MIF = 8'(IDX_MIF * 4);

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int IEN_RXAV_BIT = 0;
  localparam int IEN_TXE_BIT = 1;
  localparam int IEN_LERR_BIT = 2;
  localparam int IEN_MDM_BIT = 3;
  localparam int FS_ON_BIT = 0;
  localparam int FS_RXCLR_BIT = 1;
  localparam int FS_TXCLR_BIT = 2;
  localparam int FS_TRIG_LSB = 6;
  localparam int LFC_STB_BIT = 2;
  localparam int LFC_PEN_BIT = 3;
  localparam logic [3:0] IEN_RST = 4'h0;
  localparam logic [7:0] LFC_RST = 8'h00;
  localparam logic [1:0] TRIG_RST = 2'b00;

  // ****************************************************************
  // identification codes, bits 3:0
  // ****************************************************************
  localparam logic [3:0] IID_NONE = 4'h1;
  localparam logic [3:0] IID_LINE = 4'h6;
  localparam logic [3:0] IID_RXDATA = 4'h4;
  localparam logic [3:0] IID_TIMEOUT = 4'hC;
  localparam logic [3:0] IID_TX_HOLDING_EMPTY = 4'h2;
  localparam logic [3:0] IID_MODEM = 4'h0;

  // ****************************************************************
  // fifo sizes, trigger levels, timing counts
  // ****************************************************************
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] TRIG_LVL0 = 5'h01;
  localparam logic [CNT_W-1:0] TRIG_LVL1 = 5'h04;
  localparam logic [CNT_W-1:0] TRIG_LVL2 = 5'h08;
  localparam logic [CNT_W-1:0] TRIG_LVL3 = 5'h0E;
  localparam int TMR_W = 10;
  localparam int RCLK_PER_HALF_BIT = 8;
  localparam int TIMEOUT_CHARS = 4;
  localparam logic [2:0] STOP_HALVES_ONE = 3'h2;
  localparam logic [2:0] STOP_HALVES_ONE_HALF = 3'h3;
  localparam logic [2:0] STOP_HALVES_TWO = 3'h4;
  localparam logic [3:0] DATA_BITS_MIN = 4'h5;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic bi;
    logic fe;
    logic pe;
    logic [7:0] data;
  } ufi_rx_char_type;

  typedef struct packed {
    logic parity_on;
    logic [2:0] stop_halves;
    logic [3:0] data_bits;
  } ufi_fmt_type;

  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } ufi_modem_type;

  localparam ufi_fmt_type FMT_RST = '{parity_on: 1'b0, stop_halves: STOP_HALVES_ONE, data_bits: DATA_BITS_MIN};

endpackage

/* File: verilog/ufi_uart_irq.sv */
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module ufi_uart_irq (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // receiver side
  input wire logic rx_push,
  input wire ufi_pkg::ufi_rx_char_type rx_char,
  // transmitter side
  input wire logic tx_pop,
  input wire logic tx_shift_busy,
  output logic tx_avail,
  output logic [7:0] tx_data,
  // pins
  input wire logic rclk,
  input wire ufi_pkg::ufi_modem_type modem_in,
  // status
  output logic irq_output,
  output ufi_pkg::ufi_fmt_type line_fmt,
  output logic fifo_on
);
  import ufi_pkg::*;

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  // line format decode: word length, parity, stop count
  function automatic ufi_fmt_type fmt_of(input logic [7:0] lfc);
    ufi_fmt_type f;
    f.data_bits = DATA_BITS_MIN + {2'b00, lfc[1:0]};
    f.parity_on = lfc[LFC_PEN_BIT];
    if (!lfc[LFC_STB_BIT]) begin
      f.stop_halves = STOP_HALVES_ONE;
    end else if (lfc[1:0] == 2'b00) begin
      f.stop_halves = STOP_HALVES_ONE_HALF;
    end else begin
      f.stop_halves = STOP_HALVES_TWO;
    end
    return f;
  endfunction

  // character length in half bits: start, data, parity, all stops
  function automatic logic [TMR_W-1:0] char_halves(input ufi_fmt_type f);
    logic [TMR_W-1:0] h;
    h = TMR_W'({f.data_bits, 1'b0}) + TMR_W'({f.parity_on, 1'b0}) + TMR_W'(2);
    return h + TMR_W'(f.stop_halves);
  endfunction

  // ****************************************************************
  // ahb-lite slave: one wait state, access done in first data cycle
  // ****************************************************************
  logic pend_q;
  logic wr_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  logic [7:0] rd_val;

  wire take = hsel & htrans[1] & hready;
  wire rd_acc = pend_q & ~wr_q;
  wire wr_acc = pend_q & wr_q;
  wire [7:0] wdat = hwdata[7:0];
  wire rd_rbr = rd_acc & (addr_q == OFS_RX_TX);
  wire wr_thr = wr_acc & (addr_q == OFS_RX_TX);
  wire wr_ien = wr_acc & (addr_q == OFS_IEN);
  wire rd_iir = rd_acc & (addr_q == OFS_IID_FS);
  wire wr_fs = wr_acc & (addr_q == OFS_IID_FS);
  wire wr_lfc = wr_acc & (addr_q == OFS_LFC);
  wire rd_lsf = rd_acc & (addr_q == OFS_LSF);
  wire rd_mif = rd_acc & (addr_q == OFS_MIF);

  // hready low while the access is executed, so data is always a flop
  assign hreadyout = ~pend_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // address phase capture; only byte address bits decode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 8'h00;
    end else if (ce) begin
      pend_q <= take;
      if (take) begin
        wr_q <= hwrite;
        addr_q <= haddr[7:0];
      end
    end
  end

  // read data latch; unmapped offsets read zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata_q <= 32'h0000_0000;
    end else if (ce && rd_acc) begin
      hrdata_q <= {24'h00_0000, rd_val};
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  logic [3:0] ien_q;
  logic [7:0] lfc_q;
  ufi_fmt_type fmt_q;
  logic fifo_on_q;
  logic [1:0] trig_q;

  wire fs_toggle = wr_fs & (wdat[FS_ON_BIT] != fifo_on_q);
  wire rx_flush = fs_toggle | (wr_fs & wdat[FS_ON_BIT] & wdat[FS_RXCLR_BIT]);
  wire tx_flush = fs_toggle | (wr_fs & wdat[FS_ON_BIT] & wdat[FS_TXCLR_BIT]);
  wire ien_txe_rise = wr_ien & wdat[IEN_TXE_BIT] & ~ien_q[IEN_TXE_BIT];

  // other fifo setup bits only take while the enable bit is written set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ien_q <= IEN_RST;
      lfc_q <= LFC_RST;
      fmt_q <= FMT_RST;
      fifo_on_q <= 1'b0;
      trig_q <= TRIG_RST;
    end else if (ce) begin
      if (wr_ien) begin
        ien_q <= wdat[3:0];
      end
      if (wr_lfc) begin
        lfc_q <= wdat;
        fmt_q <= fmt_of(wdat);
      end
      if (wr_fs) begin
        fifo_on_q <= wdat[FS_ON_BIT];
      end
      if (wr_fs && wdat[FS_ON_BIT]) begin
        trig_q <= wdat[FS_TRIG_LSB +: 2];
      end
    end
  end

  assign line_fmt = fmt_q;
  assign fifo_on = fifo_on_q;

  // ****************************************************************
  // pin synchronisers and receiver clock edge
  // ****************************************************************
  logic rclk_s1_q;
  logic rclk_s2_q;
  logic rclk_s3_q;
  ufi_modem_type mdm_s1_q;
  ufi_modem_type mdm_s2_q;
  ufi_modem_type mdm_prev_q;

  wire rtick = rclk_s2_q & ~rclk_s3_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rclk_s1_q <= 1'b0;
      rclk_s2_q <= 1'b0;
      rclk_s3_q <= 1'b0;
      mdm_s1_q <= 4'h0;
      mdm_s2_q <= 4'h0;
      mdm_prev_q <= 4'h0;
    end else if (ce) begin
      rclk_s1_q <= rclk;
      rclk_s2_q <= rclk_s1_q;
      rclk_s3_q <= rclk_s2_q;
      mdm_s1_q <= modem_in;
      mdm_s2_q <= mdm_s1_q;
      mdm_prev_q <= mdm_s2_q;
    end
  end

  // ****************************************************************
  // receive fifo (depth one in character mode)
  // ****************************************************************
  ufi_rx_char_type rx_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] rx_rd_q;
  logic [PTR_W-1:0] rx_wr_q;
  logic [CNT_W-1:0] rx_cnt_q;
  logic top_seen_q;
  logic oe_q;
  logic [FIFO_DEPTH-1:0] slot_err;

  wire [CNT_W-1:0] cap = fifo_on_q ? CNT_W'(FIFO_DEPTH) : CNT_W'(1);
  wire rx_any = rx_cnt_q != '0;
  wire rx_full = rx_cnt_q == cap;
  wire rx_pop = rd_rbr & rx_any;
  // full fifo drops the new character and flags overrun, unless a read pops one in the same cycle
  wire rx_put = rx_push & (~rx_full | rx_pop);
  wire rx_ovr = rx_push & rx_full & ~rx_pop;
  ufi_rx_char_type rx_top;
  assign rx_top = rx_mem[rx_rd_q];

  // pointers and fill count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_rd_q <= '0;
      rx_wr_q <= '0;
      rx_cnt_q <= '0;
    end else if (ce) begin
      if (rx_flush) begin
        rx_rd_q <= '0;
        rx_wr_q <= '0;
        rx_cnt_q <= '0;
      end else begin
        rx_wr_q <= rx_wr_q + PTR_W'(rx_put);
        rx_rd_q <= rx_rd_q + PTR_W'(rx_pop);
        rx_cnt_q <= rx_cnt_q + CNT_W'(rx_put) - CNT_W'(rx_pop);
      end
    end
  end

  // storage, no reset: slot errors only count while valid, an empty data read returns old contents
  always_ff @(posedge clk) begin
    if (ce && rx_put) begin
      rx_mem[rx_wr_q] <= rx_char;
    end
  end

  for (genvar i = 0; i < FIFO_DEPTH; i++) begin : g_err
    wire [PTR_W-1:0] age = PTR_W'(i) - rx_rd_q;
    assign slot_err[i] = ({1'b0, age} < rx_cnt_q) & (rx_mem[i].pe | rx_mem[i].fe | rx_mem[i].bi);
  end

  // line state read clears overrun and hides top errors; set wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oe_q <= 1'b0;
      top_seen_q <= 1'b0;
    end else if (ce) begin
      if (rx_ovr) begin
        oe_q <= 1'b1;
      end else if (rd_lsf) begin
        oe_q <= 1'b0;
      end
      if (rx_pop || rx_flush) begin
        top_seen_q <= 1'b0;
      end else if (rd_lsf) begin
        top_seen_q <= 1'b1;
      end
    end
  end

  // errors travel with the character at the head
  wire [2:0] top_errs = (rx_any & ~top_seen_q) ? {rx_top.bi, rx_top.fe, rx_top.pe} : 3'b000;

  // ****************************************************************
  // transmit fifo
  // ****************************************************************
  logic [7:0] tx_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] tx_rd_q;
  logic [PTR_W-1:0] tx_wr_q;
  logic [CNT_W-1:0] tx_cnt_q;

  wire tx_empty = tx_cnt_q == '0;
  // writes to a full fifo are dropped
  wire tx_put = wr_thr & (tx_cnt_q != cap);
  wire tx_take = tx_pop & ~tx_empty;
  assign tx_avail = ~tx_empty;
  assign tx_data = tx_mem[tx_rd_q];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_rd_q <= '0;
      tx_wr_q <= '0;
      tx_cnt_q <= '0;
    end else if (ce) begin
      if (tx_flush) begin
        tx_rd_q <= '0;
        tx_wr_q <= '0;
        tx_cnt_q <= '0;
      end else begin
        tx_wr_q <= tx_wr_q + PTR_W'(tx_put);
        tx_rd_q <= tx_rd_q + PTR_W'(tx_take);
        tx_cnt_q <= tx_cnt_q + CNT_W'(tx_put) - CNT_W'(tx_take);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (ce && tx_put) begin
      tx_mem[tx_wr_q] <= wdat;
    end
  end

  // ****************************************************************
  // receive data and timeout sources
  // ****************************************************************
  logic [TMR_W-1:0] to_cnt_q;
  logic to_pend_q;

  wire [CNT_W-1:0] trig_lvl = (trig_q == 2'b00) ? TRIG_LVL0 : (trig_q == 2'b01) ? TRIG_LVL1 :
                              (trig_q == 2'b10) ? TRIG_LVL2 : TRIG_LVL3;
  // fill at or above trigger, character mode on any data
  wire rda_src = fifo_on_q ? (rx_cnt_q >= trig_lvl) : rx_any;
  wire rda_int = ien_q[IEN_RXAV_BIT] & rda_src;
  // timer idles in polled or character mode
  wire to_arm = fifo_on_q & ien_q[IEN_RXAV_BIT];
  // four character times incl. second stop bit
  wire [TMR_W-1:0] to_limit = TMR_W'(TIMEOUT_CHARS * RCLK_PER_HALF_BIT) * char_halves(fmt_q);
  // restart on arrival only while nothing pending
  wire to_restart = rx_pop | (rx_put & ~to_pend_q) | rx_flush | ~rx_any | ~to_arm;

  // timer advances on receiver clock edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      to_cnt_q <= '0;
    end else if (ce) begin
      if (to_restart) begin
        to_cnt_q <= '0;
      end else if (rtick && to_cnt_q != to_limit) begin
        to_cnt_q <= to_cnt_q + TMR_W'(1);
      end
    end
  end

  // single receive read clears pending timeout
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      to_pend_q <= 1'b0;
    end else if (ce) begin
      if (rx_pop || rx_flush || !to_arm) begin
        to_pend_q <= 1'b0;
      end else if (to_cnt_q == to_limit && rx_any) begin
        to_pend_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // transmit empty source
  // ****************************************************************
  logic tx_holding_empty_q;
  logic two_q;
  logic first_q;
  logic empty_prev_q;
  logic dly_on_q;
  logic [TMR_W-1:0] dly_cnt_q;
  logic [3:0] iid;

  wire empty_rise = tx_empty & ~empty_prev_q;
  // delay in fifo mode unless two bytes were held or first after toggle
  wire need_dly = fifo_on_q & ~two_q & ~first_q;
  wire [TMR_W-1:0] dly_limit = TMR_W'(RCLK_PER_HALF_BIT) * (char_halves(fmt_q) - TMR_W'(2));
  wire dly_done = dly_on_q & rtick & (dly_cnt_q == dly_limit);
  wire tx_holding_empty_now = tx_empty & ((empty_rise & ~need_dly) | dly_done | ien_txe_rise | first_q);

  // delay timer and history of the fifo fill
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      empty_prev_q <= 1'b1;
      dly_on_q <= 1'b0;
      dly_cnt_q <= '0;
      two_q <= 1'b0;
      first_q <= 1'b0;
    end else if (ce) begin
      empty_prev_q <= tx_empty;
      if (empty_rise && need_dly) begin
        dly_on_q <= 1'b1;
        dly_cnt_q <= '0;
      end else if (dly_done || !tx_empty) begin
        dly_on_q <= 1'b0;
      end else if (dly_on_q && rtick) begin
        dly_cnt_q <= dly_cnt_q + TMR_W'(1);
      end
      if (tx_cnt_q >= CNT_W'(2)) begin
        two_q <= 1'b1;
      end else if (tx_holding_empty_now) begin
        two_q <= 1'b0;
      end
      if (fs_toggle) begin
        first_q <= 1'b1;
      end else if (tx_holding_empty_now) begin
        first_q <= 1'b0;
      end
    end
  end

  // cleared by holding write or identification read; set wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_holding_empty_q <= 1'b0;
    end else if (ce) begin
      if (tx_holding_empty_now) begin
        tx_holding_empty_q <= 1'b1;
      end else if (wr_thr || (rd_iir && iid == IID_TX_HOLDING_EMPTY) || !tx_empty) begin
        tx_holding_empty_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // modem deltas
  // ****************************************************************
  logic [3:0] delta_q;
  // cts, dsr, ring trailing edge, carrier changes
  wire [3:0] m_chg = {mdm_s2_q.dcd ^ mdm_prev_q.dcd, mdm_prev_q.ri & ~mdm_s2_q.ri,
                      mdm_s2_q.dsr ^ mdm_prev_q.dsr, mdm_s2_q.cts ^ mdm_prev_q.cts};

  // modem read clears, a change in the same cycle survives
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      delta_q <= 4'h0;
    end else if (ce) begin
      delta_q <= m_chg | (delta_q & ~{4{rd_mif}});
    end
  end

  // ****************************************************************
  // prioritisation and read values
  // ****************************************************************
  // enables gate each source
  // overrun or an unseen error on the head character raises line status
  wire ls_int = ien_q[IEN_LERR_BIT] & (oe_q | (|top_errs));
  wire tx_holding_empty_int = ien_q[IEN_TXE_BIT] & tx_holding_empty_q;
  wire ms_int = ien_q[IEN_MDM_BIT] & (|delta_q);
  // pending timeout hidden at once when its enable drops, not a cycle late
  wire to_int = to_pend_q & to_arm;

  assign iid = ls_int ? IID_LINE : rda_int ? IID_RXDATA : to_int ? IID_TIMEOUT :
               tx_holding_empty_int ? IID_TX_HOLDING_EMPTY : ms_int ? IID_MODEM : IID_NONE;
  assign irq_output = ls_int | rda_int | to_int | tx_holding_empty_int | ms_int;

  wire [7:0] lsf_val = {fifo_on_q & (|slot_err), tx_empty & ~tx_shift_busy, tx_empty, top_errs, oe_q, rx_any};

  // register read mux; identification layout
  always_comb begin
    case (addr_q)
      OFS_RX_TX: rd_val = rx_top.data;
      OFS_IEN: rd_val = {4'h0, ien_q};
      OFS_IID_FS: rd_val = {fifo_on_q, fifo_on_q, 2'b00, iid};
      OFS_LFC: rd_val = lfc_q;
      OFS_LSF: rd_val = lsf_val;
      OFS_MIF: rd_val = {mdm_s2_q, delta_q};
      default: rd_val = 8'h00;
    endcase
  end

endmodule
